// >>> rtl/acs_bit_clock.sv
// Conversion bit-period tick generator.
`timescale 1ns/100ps
module acs_bit_clock import acs_pkg::*; #(
	parameter int RC_BIT_CYCLES = RC_BIT_CYCLES_DFLT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [1:0] clk_sel,
	output logic tick
);
	// The widest prescale sets the width, so a short internal bit time
	// cannot truncate the divide-by-64 limit.
	localparam int MAX_CYCLES = (RC_BIT_CYCLES > DIV64_CYCLES) ?
		RC_BIT_CYCLES : DIV64_CYCLES;
	localparam int CW = $clog2(MAX_CYCLES + 1);

	logic [CW-1:0] cnt_reg, cnt_next, limit;
	logic tick_reg, tick_next;

	always_comb begin
		case (clk_sel)
		CLK_DIV16: limit = CW'(DIV16_CYCLES - 1);
		CLK_DIV4: limit = CW'(DIV4_CYCLES - 1);
		CLK_DIV64: limit = CW'(DIV64_CYCLES - 1);
		default: limit = CW'(RC_BIT_CYCLES - 1);
		endcase
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!run) begin
			cnt_next = '0;
		end else if (cnt_reg >= limit) begin
			cnt_next = '0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule // acs_bit_clock

// >>> rtl/acs_pkg.sv
// Shared constants and types of the converter sequencer.
package acs_pkg;

	// ==========================================================
	// Register map: indices, byte address is four times the index
	// ==========================================================
	localparam logic [5:0] IDX_PIN_ENABLE = 6'h08;
	localparam logic [5:0] IDX_CONTROL = 6'h09;
	localparam logic [5:0] IDX_RESULT_BYTE = 6'h0B;
	localparam logic [5:0] IDX_RESULT_HIGH = 6'h0C;
	localparam logic [5:0] IDX_RESULT_LOW = 6'h0D;
	localparam logic [5:0] IDX_STATUS = 6'h0E;

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int CTL_REF_SRC = 7;
	localparam int CTL_CLK_HI = 6;
	localparam int CTL_CLK_LO = 5;
	localparam int CTL_RUN = 4;
	localparam int CTL_POWER = 3;
	localparam int CTL_CHAN_HI = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;

	// Status register fields.
	localparam int STS_DONE = 0;
	localparam int STS_WAKE_EN = 1;
	localparam int STS_IRQ_EN = 2;
	localparam int STS_SLEEPING = 3;
	localparam int STS_BUSY = 4;

	// ==========================================================
	// Conversion clock selection
	// ==========================================================
	localparam logic [1:0] CLK_DIV16 = 2'h0;
	localparam logic [1:0] CLK_DIV4 = 2'h1;
	localparam logic [1:0] CLK_DIV64 = 2'h2;
	localparam logic [1:0] CLK_RC = 2'h3;
	localparam int DIV16_CYCLES = 16;
	localparam int DIV4_CYCLES = 4;
	localparam int DIV64_CYCLES = 64;

	// Internal oscillator bit time, longest time rounds down.
	localparam int CLK_PERIOD_NS = 10;
	localparam int RC_BIT_TIME_NS = 71000;
	localparam int RC_BIT_CYCLES_DFLT = RC_BIT_TIME_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Conversion frame
	// ==========================================================
	localparam int RES_W = 12;
	localparam int BIT_PERIODS = 15;
	localparam int SAMPLE_PERIODS = BIT_PERIODS - RES_W;

	// ==========================================================
	// Bus answers
	// ==========================================================
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic power;
		logic ref_enable;
		logic ref_external;
		logic sample;
		logic [2:0] channel;
		logic [RES_W-1:0] trial_code;
	} acs_analog_t;

endpackage

// >>> rtl/acs_sar_engine.sv
// Successive-approximation stepping over one fifteen-period frame.
`timescale 1ns/100ps
module acs_sar_engine import acs_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic tick,
	input wire logic comp_in,
	output logic busy,
	output logic sample,
	output logic done,
	output logic [RES_W-1:0] trial,
	output logic [RES_W-1:0] result
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DECIDE} acs_sar_st_t;

	acs_sar_st_t st_reg, st_next;
	logic [3:0] per_reg, per_next;
	logic [RES_W-1:0] mask_reg, mask_next, code_reg, code_next;
	logic done_reg, done_next;

	always_comb begin
		st_next = st_reg;
		per_next = per_reg;
		mask_next = mask_reg;
		code_next = code_reg;
		done_next = 1'b0;
		case (st_reg)
		ST_IDLE: begin
			if (start) begin
				st_next = ST_SAMPLE;
				per_next = '0;
			end
		end
		ST_SAMPLE: begin
			if (tick) begin
				per_next = per_reg + 4'd1;
				if (per_reg == 4'(SAMPLE_PERIODS - 1)) begin
					st_next = ST_DECIDE;
					mask_next = {1'b1, {(RES_W-1){1'b0}}};
					code_next = '0;
				end
			end
		end
		default: begin
			if (tick) begin
				per_next = per_reg + 4'd1;
				// Keep the trial bit when the input is at or above it.
				if (comp_in) begin
					code_next = code_reg | mask_reg;
				end
				mask_next = mask_reg >> 1;
				if (per_reg == 4'(BIT_PERIODS - 1)) begin
					st_next = ST_IDLE;
					done_next = 1'b1;
				end
			end
		end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			per_reg <= '0;
			mask_reg <= '0;
			code_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			per_reg <= per_next;
			mask_reg <= mask_next;
			code_reg <= code_next;
			done_reg <= done_next;
		end
	end

	assign busy = (st_reg != ST_IDLE);
	assign sample = (st_reg == ST_SAMPLE);
	assign done = done_reg;
	assign trial = code_reg | mask_reg;
	assign result = code_reg;
endmodule // acs_sar_engine

// >>> rtl/acs_sequencer.sv
// Converter sequencer top: register slave, sleep handling and conversion.
// Notes on behaviour
// - Divided clock: 15 bit periods per conversion.
// - Fourth clock code: internal oscillator bit time.
// - Sleep halts core, conversion keeps running.
// - Hardware clears run bit at conversion end.
// - Completion loads byte, high and low results.
// - Completion in sleep with wake enabled wakes.
// - Otherwise completion in sleep shuts converter off.
// - Power bit gates converter and reference network.
// - Writing run bit one starts a conversion.
// - Channel change clears results; ignored while done flag set.
// - Non-analog pins stay digital input or output.
// - Completion sets done flag with run clear.
// - Writing run bit zero does nothing.
// - Channel bits writable only when idle, flag low.
// - Clock codes: 16, 4, 64, internal oscillator.
`timescale 1ns/100ps
module acs_sequencer import acs_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int RC_BIT_CYCLES = RC_BIT_CYCLES_DFLT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_instruction,
	input wire logic other_wake,
	input wire logic comp_in,
	output logic core_halted,
	output logic wake_pulse,
	output logic conv_irq,
	output logic [7:0] analog_pin_bits,
	output acs_analog_t analog
);
	// ==========================================================
	// Bus slave state
	// ==========================================================
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wlane_reg, wlane_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	// ==========================================================
	// Registers and sequencing state
	// ==========================================================
	logic [7:0] pins_reg, pins_next, ctl_reg, ctl_next;
	logic [RES_W-1:0] res_reg, res_next;
	logic done_reg, done_next, wake_en_reg, wake_en_next;
	logic irq_en_reg, irq_en_next, irq_reg, irq_next;
	logic sleep_reg, sleep_next, shut_reg, shut_next;
	logic wake_reg, wake_next, start_reg, start_next;
	acs_analog_t ana_reg, ana_next;

	logic do_write;
	logic [5:0] w_idx, r_idx;
	logic eng_busy, eng_sample, eng_done, tick;
	logic [RES_W-1:0] eng_trial, eng_result;
	logic [7:0] rd_byte;
	logic rd_hit;

	assign w_idx = awaddr_reg[7:2];
	assign r_idx = s_axi_araddr[7:2];
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	acs_bit_clock #(
		.RC_BIT_CYCLES(RC_BIT_CYCLES)
	) u_bit_clock (
		.mclk(mclk),
		.rst(rst),
		.run(eng_busy),
		.clk_sel(ctl_reg[CTL_CLK_HI:CTL_CLK_LO]),
		.tick(tick)
	);

	acs_sar_engine u_engine (
		.mclk(mclk),
		.rst(rst),
		.start(start_reg),
		.tick(tick),
		.comp_in(comp_in),
		.busy(eng_busy),
		.sample(eng_sample),
		.done(eng_done),
		.trial(eng_trial),
		.result(eng_result)
	);

	// ==========================================================
	// Read decode
	// ==========================================================
	always_comb begin
		rd_hit = 1'b1;
		if (r_idx == IDX_PIN_ENABLE) begin
			rd_byte = pins_reg;
		end else if (r_idx == IDX_CONTROL) begin
			rd_byte = ctl_reg;
		end else if (r_idx == IDX_RESULT_BYTE) begin
			rd_byte = res_reg[RES_W-1:RES_W-8];
		end else if (r_idx == IDX_RESULT_HIGH) begin
			rd_byte = {4'h0, res_reg[RES_W-1:8]};
		end else if (r_idx == IDX_RESULT_LOW) begin
			rd_byte = res_reg[7:0];
		end else if (r_idx == IDX_STATUS) begin
			rd_byte = {3'h0, eng_busy, sleep_reg, irq_en_reg,
				wake_en_reg, done_reg};
		end else begin
			rd_byte = 8'h00;
			rd_hit = 1'b0;
		end
	end

	// ==========================================================
	// Bus handshakes
	// ==========================================================
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && !aw_held_reg) begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_reg) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (w_idx == IDX_PIN_ENABLE ||
				w_idx == IDX_CONTROL || w_idx == IDX_STATUS ||
				w_idx == IDX_RESULT_BYTE || w_idx == IDX_RESULT_HIGH ||
				w_idx == IDX_RESULT_LOW) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next = {24'h000000, rd_byte};
			rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// ==========================================================
	// Register writes and conversion sequencing
	// ==========================================================
	always_comb begin
		pins_next = pins_reg;
		ctl_next = ctl_reg;
		res_next = res_reg;
		done_next = done_reg;
		wake_en_next = wake_en_reg;
		irq_en_next = irq_en_reg;
		sleep_next = sleep_reg;
		shut_next = shut_reg;
		wake_next = 1'b0;
		start_next = 1'b0;
		if (do_write && wlane_reg) begin
			if (w_idx == IDX_PIN_ENABLE) begin
				pins_next = wdata_reg;
			end else if (w_idx == IDX_CONTROL) begin
				ctl_next[CTL_REF_SRC:CTL_CLK_LO] =
					wdata_reg[CTL_REF_SRC:CTL_CLK_LO];
				ctl_next[CTL_POWER] = wdata_reg[CTL_POWER];
				// Run only rises from software; a zero is ignored.
				if (wdata_reg[CTL_RUN] && !ctl_reg[CTL_RUN]) begin
					ctl_next[CTL_RUN] = 1'b1;
					start_next = 1'b1;
				end
				if (!done_reg && !ctl_reg[CTL_RUN]) begin
					ctl_next[CTL_CHAN_HI:0] = wdata_reg[CTL_CHAN_HI:0];
					if (wdata_reg[CTL_CHAN_HI:0] !=
						ctl_reg[CTL_CHAN_HI:0]) begin
						res_next = '0;
					end
				end
			end else if (w_idx == IDX_STATUS) begin
				// Done flag is write-one-to-clear.
				if (wdata_reg[STS_DONE]) begin
					done_next = 1'b0;
				end
				wake_en_next = wdata_reg[STS_WAKE_EN];
				irq_en_next = wdata_reg[STS_IRQ_EN];
			end
		end
		if (sleep_instruction) begin
			sleep_next = 1'b1;
		end
		if (sleep_reg && other_wake) begin
			sleep_next = 1'b0;
			wake_next = 1'b1;
		end
		// Completion placed last so it wins over a same-cycle clear.
		if (eng_done) begin
			res_next = eng_result;
			ctl_next[CTL_RUN] = 1'b0;
			done_next = 1'b1;
			if (sleep_reg && wake_en_reg) begin
				sleep_next = 1'b0;
				wake_next = 1'b1;
			end else if (sleep_reg) begin
				shut_next = 1'b1;
			end
		end
		if (!sleep_next) begin
			shut_next = 1'b0;
		end
	end

	// Analog side is registered so every pin comes from a flop.
	always_comb begin
		ana_next.power = ctl_reg[CTL_POWER] && !shut_reg;
		ana_next.ref_enable = ctl_reg[CTL_POWER] && !shut_reg;
		ana_next.ref_external = ctl_reg[CTL_REF_SRC];
		ana_next.sample = eng_sample;
		ana_next.channel = ctl_reg[CTL_CHAN_HI:0];
		ana_next.trial_code = eng_trial;
		irq_next = done_reg && irq_en_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
			pins_reg <= PIN_ENABLE_RESET;
			ctl_reg <= CONTROL_RESET;
			res_reg <= '0;
			done_reg <= 1'b0;
			wake_en_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			irq_reg <= 1'b0;
			sleep_reg <= 1'b0;
			shut_reg <= 1'b0;
			wake_reg <= 1'b0;
			start_reg <= 1'b0;
			ana_reg <= '0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			pins_reg <= pins_next;
			ctl_reg <= ctl_next;
			res_reg <= res_next;
			done_reg <= done_next;
			wake_en_reg <= wake_en_next;
			irq_en_reg <= irq_en_next;
			irq_reg <= irq_next;
			sleep_reg <= sleep_next;
			shut_reg <= shut_next;
			wake_reg <= wake_next;
			start_reg <= start_next;
			ana_reg <= ana_next;
		end
	end

	// Write readies are the holding flags inverted and read ready is rvalid inverted, so all stay flop-driven.
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign core_halted = sleep_reg;
	assign wake_pulse = wake_reg;
	assign conv_irq = irq_reg;
	// A zero bit leaves its pin to ordinary digital use.
	assign analog_pin_bits = pins_reg;
	assign analog = ana_reg;
endmodule // acs_sequencer

// >>> verif/acs_analog_model.sv
// Behavioural comparator facing the sequencer's analog side.
`timescale 1ns/100ps
module acs_analog_model import acs_pkg::*; (
	input wire logic mclk,
	input wire acs_analog_t analog,
	input wire logic [RES_W-1:0] vin,
	output logic comp_in
);
	logic tgl = 1'b0;
	// An unpowered comparator gives no stable answer, so it wanders.
	always @(posedge mclk) begin
		tgl <= ~tgl;
	end
	always_comb begin
		comp_in = analog.power ? (vin >= analog.trial_code) : tgl;
	end
endmodule // acs_analog_model

// >>> verif/acs_sequencer_checker.sv
// Port-level assertions for the converter sequencer.
`timescale 1ns/100ps
module acs_sequencer_checker import acs_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic sleep_instruction,
	input wire logic other_wake,
	input wire logic core_halted,
	input wire logic wake_pulse,
	input wire logic [7:0] analog_pin_bits,
	input wire acs_analog_t analog
);
	// ========
	// Clocking
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ========
	// Sleep
	property p_wake;
		wake_pulse |-> !core_halted && $past(core_halted);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake pulse without leaving sleep");
	property p_sleep;
		sleep_instruction && !core_halted && !other_wake |=> core_halted;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep not entered");
	property p_off;
		core_halted && !other_wake && $fell(analog.power) |=> !analog.power;
	endproperty
	a_off: assert property (p_off)
		else $error("converter back on during sleep");
	// ========
	// Converter
	property p_ref;
		!analog.power |-> !analog.ref_enable;
	endproperty
	a_ref: assert property (p_ref)
		else $error("reference on while unpowered");
	property p_smp;
		$rose(analog.sample) |-> analog.sample[*6];
	endproperty
	a_smp: assert property (p_smp)
		else $error("sample phase too short");
	property p_gap;
		$fell(analog.sample) |-> !analog.sample[*8];
	endproperty
	a_gap: assert property (p_gap)
		else $error("sampling restarted early");
	property p_pins;
		$changed(analog_pin_bits) |-> $rose(s_axi_bvalid);
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin mode changed without a write");
	// ========
	// Bus
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped");
	property p_arrdy;
		s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_arrdy: assert property (p_arrdy)
		else $error("read address taken while busy");
endmodule // acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker u_chk (.mclk, .rst, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .sleep_instruction, .other_wake, .core_halted,
	.wake_pulse, .analog_pin_bits, .analog);

// >>> verif/acs_sequencer_test.sv
// Self-checking bench of the converter sequencer.
`timescale 1ns/100ps
`define CHK(a, e) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		err_count++; \
		$display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); \
	end \
end
module acs_sequencer_test import acs_pkg::*;;
	// Short internal oscillator bit time keeps the run brief.
	localparam int RCB = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic sleep_instruction = 1'b0;
	logic other_wake = 1'b0;
	logic [11:0] vin = 12'h000;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, core_halted, wake_pulse, conv_irq, comp_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic [31:0] s_axi_rdata, rd_d;
	logic [7:0] analog_pin_bits;
	acs_analog_t analog;
	int err_count = 0;
	int num_checks = 0;
	int wk_cnt = 0;

	acs_sequencer #(.RC_BIT_CYCLES(RCB)) dut (.mclk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sleep_instruction, .other_wake, .comp_in, .core_halted,
		.wake_pulse, .conv_irq, .analog_pin_bits, .analog);
	acs_analog_model u_ana (.mclk, .analog, .vin, .comp_in);

	always #5 mclk = ~mclk;

	// Wake pulses last one cycle, so they are counted as they pass.
	always @(posedge mclk) begin
		if (wake_pulse === 1'b1) begin
			wk_cnt <= wk_cnt + 1;
		end
	end

	// ========
	// Bus tasks
	task conclude;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 5000) begin
			err_count++;
			conclude();
		end
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d);
		int n;
		logic a, w;
		n = 0;
		a = 1'b0;
		w = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge mclk);
			n++;
			tmo(n);
			if (!a && s_axi_awready === 1'b1) begin
				a = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge mclk);
			n++;
			tmo(n);
		end while (s_axi_bvalid !== 1'b1);
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [5:0] i);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			tmo(n);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
			tmo(n);
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rchk(input logic [5:0] i, input logic [31:0] e);
		rd(i);
		`CHK(rd_d, e)
	endtask
	task wirq(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			tmo(n);
		end while (conv_irq !== 1'b1);
	endtask

	// ========
	// Scenarios
	task t_regs;
		rchk(IDX_CONTROL, {24'h0, CONTROL_RESET});
		rchk(IDX_PIN_ENABLE, {24'h0, PIN_ENABLE_RESET});
		wr(IDX_PIN_ENABLE, 8'hA5);
		@(negedge mclk);
		`CHK(analog_pin_bits, 8'hA5)
		rchk(IDX_PIN_ENABLE, 32'hA5);
		wr(6'h10, 8'h01);
		`CHK(wr_r, RESP_SLVERR)
		rchk(6'h10, 32'h0);
		`CHK(rd_r, RESP_SLVERR)
	endtask
	task t_conv(input logic [1:0] sel, input logic [11:0] v,
		input logic [2:0] ch);
		int n, p;
		p = (sel == CLK_DIV4) ? DIV4_CYCLES : (sel == CLK_DIV16) ?
			DIV16_CYCLES : (sel == CLK_DIV64) ? DIV64_CYCLES : RCB;
		vin = v;
		repeat (2 * p) @(posedge mclk);
		wr(IDX_STATUS, 8'h05);
		wr(IDX_CONTROL, {1'b0, sel, 2'b11, ch});
		@(negedge mclk);
		`CHK(analog.channel, ch)
		`CHK(analog.ref_enable, 1'b1)
		wirq(n);
		`CHK(n >= 14 * p && n <= 16 * p + 8, 1'b1)
		rchk(IDX_CONTROL, {24'h0, 1'b0, sel, 2'b01, ch});
		rchk(IDX_STATUS, 32'h5);
		rchk(IDX_RESULT_BYTE, {24'h0, v[11:4]});
		rchk(IDX_RESULT_HIGH, {28'h0, v[11:8]});
		rchk(IDX_RESULT_LOW, {24'h0, v[7:0]});
		`CHK(conv_irq, 1'b1)
		wr(IDX_STATUS, 8'h05);
		rchk(IDX_STATUS, 32'h4);
		`CHK(conv_irq, 1'b0)
	endtask
	task t_norun;
		int n;
		vin = 12'h3C1;
		wr(IDX_CONTROL, 8'h39);
		wr(IDX_CONTROL, 8'h2E);
		rchk(IDX_CONTROL, 32'h39);
		wirq(n);
		wr(IDX_CONTROL, 8'h2E);
		rchk(IDX_CONTROL, 32'h29);
		wr(IDX_STATUS, 8'h05);
		wr(IDX_CONTROL, 8'h2E);
		rchk(IDX_CONTROL, 32'h2E);
		rchk(IDX_RESULT_LOW, 32'h0);
		rchk(IDX_STATUS, 32'h4);
	endtask
	task t_sleep(input logic we);
		int n, w0;
		vin = 12'h7E2;
		w0 = wk_cnt;
		wr(IDX_STATUS, {5'h0, 1'b1, we, 1'b1});
		wr(IDX_CONTROL, 8'h39);
		sleep_instruction <= 1'b1;
		@(posedge mclk);
		sleep_instruction <= 1'b0;
		@(negedge mclk);
		`CHK(core_halted, 1'b1)
		wirq(n);
		@(negedge mclk);
		`CHK(core_halted, !we)
		`CHK(analog.power, we)
		`CHK(wk_cnt - w0, we)
		@(posedge mclk);
		other_wake <= 1'b1;
		@(posedge mclk);
		other_wake <= 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(analog.power, 1'b1)
		`CHK(core_halted, 1'b0)
		`CHK(wk_cnt - w0, 1)
		rchk(IDX_CONTROL, 32'h29);
		rchk(IDX_RESULT_HIGH, 32'h7);
		wr(IDX_STATUS, 8'h05);
	endtask
	task t_pwr;
		wr(IDX_CONTROL, 8'h81);
		@(negedge mclk);
		`CHK(analog.ref_external, 1'b1)
		`CHK(analog.power, 1'b0)
		`CHK(analog.ref_enable, 1'b0)
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_conv(CLK_DIV16, 12'hA5C, 3'h1);
		t_conv(CLK_DIV4, 12'hFFF, 3'h2);
		t_conv(CLK_DIV64, 12'h000, 3'h3);
		t_conv(CLK_RC, 12'h813, 3'h4);
		t_norun();
		t_sleep(1'b1);
		t_sleep(1'b0);
		t_pwr();
		conclude();
	end
endmodule // acs_sequencer_test
